/* logic/ssrp_device.sv */
// The address-and-strobe port was left to the implementer.
`default_nettype none
`include "ssrp_consts.svh"
module ssrp_device (
  input  wire logic       sys_clk,                    // system clock
  input  wire logic       reset,                      // synchronous reset
  ssrp_if.device          bus,                        // two-wire link
  input  wire logic [1:0] first_high_voltage_input,   // {ov, uv}
  input  wire logic [1:0] second_high_voltage_input,  // {above on, below off}
  input  wire logic       supply_cutoff_output,       // shutdown level
  input  wire logic       slave_address_select_pin,   // address LSB
  input  wire logic       prog_verify_ok,             // programming check
  output logic            sda_o,                      // data line level
  output logic            sda_oe,                     // data line enable
  output logic      [7:0] register_pointer,           // current pointer
  output logic      [7:0] write_data,                 // last written byte
  output logic            write_strobe,               // data byte taken
  output logic      [7:0] disable_bits,               // set-only register
  output logic      [7:0] fault_status                // status value
);
  // --------------------------------------------------------------
  // Synchronisers.
  // --------------------------------------------------------------
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic       scl_d;
  logic       sda_d;
  logic       cut_d;
  always_ff @(posedge sys_clk) begin
    sync1 <= {bus.scl, bus.sda, supply_cutoff_output,
              slave_address_select_pin, first_high_voltage_input,
              second_high_voltage_input, prog_verify_ok};
    sync2 <= sync1;
  end
  logic       scl;
  logic       sda;
  logic       cut;
  logic       sel;
  logic [3:0] cmp;
  logic       ok;
  assign {scl, sda, cut, sel, cmp, ok} = sync2;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cut_d <= 1'b0;
    end else begin
      scl_d <= scl;
      sda_d <= sda;
      cut_d <= cut;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  assign scl_rise = scl && !scl_d;
  assign scl_fall = !scl && scl_d;
  assign start_c  = scl && scl_d && sda_d && !sda;
  assign stop_c   = scl && scl_d && !sda_d && sda;

  logic [7:0] status;
  ssrp_fault_status u_status (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .comparators  (cmp),
    .cutoff_event (cut && !cut_d),
    .status       (status)
  );

  // --------------------------------------------------------------
  // Byte engine.
  // --------------------------------------------------------------
  ssrp_pkg::ssrp_state_type state;
  ssrp_pkg::ssrp_state_type next_state;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [1:0] nbyte;
  logic [1:0] next_nbyte;
  logic       is_read;
  logic       next_is_read;
  logic [7:0] next_pointer;
  logic [7:0] next_wdata;
  logic       next_wstrobe;
  logic [7:0] next_disable;
  logic       next_sda_o;
  logic       next_sda_oe;
  logic [7:0] rd_byte;

  // Readback is pure selection, so reading never disturbs state.
  always_comb begin
    rd_byte = 8'h00;
    if (register_pointer[6:0] == `SSRP_REG_STATUS)
      rd_byte = status;
    else if (register_pointer[6:0] == `SSRP_REG_DISABLE)
      rd_byte = disable_bits;
    rd_byte[7] = register_pointer[`SSRP_PTR_PROG_BIT] && ok;
  end

  always_comb begin
    next_state   = state;
    next_bitcnt  = bitcnt;
    next_shift   = shift;
    next_nbyte   = nbyte;
    next_is_read = is_read;
    next_pointer = register_pointer;
    next_wdata   = write_data;
    next_wstrobe = 1'b0;
    next_disable = disable_bits;
    next_sda_o   = 1'b0;
    next_sda_oe  = sda_oe;
    if (start_c) begin
      next_state  = ssrp_pkg::ssrp_addr_type;
      next_bitcnt = 4'h0;
      next_sda_oe = 1'b0;
    end else if (stop_c) begin
      next_state  = ssrp_pkg::ssrp_idle_type;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ssrp_pkg::ssrp_addr_type, ssrp_pkg::ssrp_wbyte_type: begin
          if (scl_rise) begin
            next_shift  = {shift[6:0], sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == 4'h8) begin
            next_bitcnt = 4'h0;
            if (state == ssrp_pkg::ssrp_addr_type) begin
              if (shift[7:1] == {`SSRP_ADDR_UPPER, sel}) begin
                next_state   = ssrp_pkg::ssrp_aack_type;
                next_is_read = shift[0];
                next_nbyte   = 2'h0;
                next_sda_oe  = 1'b1;
              end else
                next_state = ssrp_pkg::ssrp_skip_type;
            end else if (nbyte == 2'h0) begin
              next_pointer = shift;
              next_nbyte   = 2'h1;
              next_state   = ssrp_pkg::ssrp_wack_type;
              next_sda_oe  = 1'b1;
            end else if (nbyte == 2'h1) begin
              next_wdata   = shift;
              next_wstrobe = 1'b1;
              next_nbyte   = 2'h2;
              if (register_pointer[6:0] == `SSRP_REG_DISABLE)
                next_disable = disable_bits |
                  (shift & `SSRP_DISABLE_MASK);
              next_state  = ssrp_pkg::ssrp_wack_type;
              next_sda_oe = 1'b1;
            end else
              next_state = ssrp_pkg::ssrp_skip_type;
          end
        end
        ssrp_pkg::ssrp_aack_type, ssrp_pkg::ssrp_wack_type: begin
          if (scl_fall) begin
            if (state == ssrp_pkg::ssrp_aack_type && is_read) begin
              next_state  = ssrp_pkg::ssrp_rbyte_type;
              next_shift  = {rd_byte[6:0], 1'b0};
              next_sda_o  = rd_byte[7];
              next_sda_oe = !rd_byte[7];
              next_bitcnt = 4'h1;
            end else begin
              next_state  = ssrp_pkg::ssrp_wbyte_type;
              next_sda_oe = 1'b0;
            end
          end
        end
        ssrp_pkg::ssrp_rbyte_type: begin
          // Drive low only; a one is a released line.
          next_sda_oe = sda_oe;
          if (scl_fall) begin
            if (bitcnt == 4'h8) begin
              next_state  = ssrp_pkg::ssrp_rack_type;
              next_sda_oe = 1'b0;
            end else begin
              next_sda_oe = !shift[7];
              next_shift  = {shift[6:0], 1'b0};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        ssrp_pkg::ssrp_rack_type:
          // One byte per read; wait for the stop.
          if (scl_fall) next_state = ssrp_pkg::ssrp_skip_type;
        ssrp_pkg::ssrp_skip_type, ssrp_pkg::ssrp_idle_type:
          next_sda_oe = 1'b0;
        default: begin
          next_state  = ssrp_pkg::ssrp_idle_type;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state            <= ssrp_pkg::ssrp_idle_type;
      bitcnt           <= 4'h0;
      shift            <= 8'h00;
      nbyte            <= 2'h0;
      is_read          <= 1'b0;
      register_pointer <= 8'h00;
      write_data       <= 8'h00;
      write_strobe     <= 1'b0;
      disable_bits     <= 8'h00;
      sda_o            <= 1'b0;
      sda_oe           <= 1'b0;
      fault_status     <= `SSRP_STATUS_RESET;
    end else begin
      state            <= next_state;
      bitcnt           <= next_bitcnt;
      shift            <= next_shift;
      nbyte            <= next_nbyte;
      is_read          <= next_is_read;
      register_pointer <= next_pointer;
      write_data       <= next_wdata;
      write_strobe     <= next_wstrobe;
      disable_bits     <= next_disable;
      sda_o            <= next_sda_o;
      sda_oe           <= next_sda_oe;
      fault_status     <= status;
    end
  end

  // The device never drives the clock line.
  assign bus.sda_s_o  = sda_o;
  assign bus.sda_s_oe = sda_oe;
endmodule : ssrp_device
`default_nettype wire

/* logic/ssrp_consts.svh */
`ifndef SSRP_CONSTS_SVH
`define SSRP_CONSTS_SVH
`define SSRP_ADDR_UPPER     6'b010111
`define SSRP_REG_STATUS     7'h19
`define SSRP_REG_DISABLE    7'h18
`define SSRP_STATUS_RESET   8'h40
`define SSRP_DISABLE_MASK   8'h1b
`define SSRP_PTR_PROG_BIT   7
`define SSRP_CODE_NONE      3'h0
`define SSRP_CODE_UV        3'h1
`define SSRP_CODE_OV        3'h2
`define SSRP_CODE_OFF       3'h4
`define SSRP_HALF_PERIOD    8'd31
`endif

/* logic/ssrp_pkg.sv */
`default_nettype none
package ssrp_pkg;
  typedef enum logic [3:0] {
    ssrp_idle_type  = 4'h0,
    ssrp_addr_type  = 4'h1,
    ssrp_aack_type  = 4'h3,
    ssrp_wbyte_type = 4'h2,
    ssrp_wack_type  = 4'h6,
    ssrp_rbyte_type = 4'h7,
    ssrp_rack_type  = 4'h5,
    ssrp_skip_type  = 4'h4
  } ssrp_state_type;

  typedef enum logic [3:0] {
    ssrpm_idle_type  = 4'h0,
    ssrpm_start_type = 4'h1,
    ssrpm_low_type   = 4'h3,
    ssrpm_high_type  = 4'h2,
    ssrpm_stop0_type = 4'h6,
    ssrpm_stop1_type = 4'h7,
    ssrpm_stop2_type = 4'h5
  } ssrp_mstate_type;
endpackage : ssrp_pkg
`default_nettype wire

/* logic/ssrp_if.sv */
`default_nettype none
interface ssrp_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  // Open-drain wired AND with pull-ups.
  wire scl = !(scl_oe && !scl_o);
  wire sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);

  modport device (
    input  scl,
    input  sda,
    output sda_s_o,
    output sda_s_oe
  );
  modport master (
    input  scl,
    input  sda,
    output scl_o,
    output scl_oe,
    output sda_m_o,
    output sda_m_oe
  );
endinterface : ssrp_if
`default_nettype wire

/* logic/ssrp_fault_status.sv */
`default_nettype none
`include "ssrp_consts.svh"
module ssrp_fault_status (
  input  wire logic       sys_clk,       // system clock
  input  wire logic       reset,         // synchronous reset
  input  wire logic [3:0] comparators,   // synchronised comparator levels
  input  wire logic       cutoff_event,  // one-cycle shutdown pulse
  output logic      [7:0] status         // register value
);
  logic [2:0] code;
  logic [2:0] next_code;

  // --------------------------------------------------------------
  // Fault code captured at shutdown.
  // --------------------------------------------------------------
  always_comb begin
    next_code = code;
    if (cutoff_event) begin
      next_code = `SSRP_CODE_NONE;
      if (comparators[2])
        next_code = next_code | `SSRP_CODE_UV;
      else if (comparators[3])
        next_code = next_code | `SSRP_CODE_OV;
      if (comparators[0])
        next_code = next_code | `SSRP_CODE_OFF;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset)
      code <= 3'(`SSRP_STATUS_RESET >> 4);
    else
      code <= next_code;
  end

  // Low nibble is live and never latched.
  assign status = {1'b0, code, comparators};
endmodule : ssrp_fault_status
`default_nettype wire

/* logic/ssrp_master.sv */
`default_nettype none
`include "ssrp_consts.svh"
module ssrp_master (
  input  wire logic       sys_clk,    // system clock
  input  wire logic       reset,      // synchronous reset
  ssrp_if.master          bus,        // two-wire link
  input  wire logic [2:0] addr,       // register address
  input  wire logic [7:0] wdata,      // write data
  input  wire logic       wr,         // write strobe
  input  wire logic       rd,         // read strobe
  output logic      [7:0] rdata       // read data
);
  // --------------------------------------------------------------
  // Registers: 0 ctrl(w: b0 go,b1 read,b2 with data, neither b1 nor b2 pointer only),
  // 1 slave LSB, 2 pointer, 3 data, 4 status, 5 read byte.
  // --------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] ptr;
  logic [7:0] dat;
  logic [7:0] rbyte;
  logic       busy;
  logic       nack;
  logic       asel;
  logic [7:0] next_rdata;

  logic [1:0] sy1;
  logic [1:0] sy2;
  always_ff @(posedge sys_clk) begin
    sy1 <= {bus.scl, bus.sda};
    sy2 <= sy1;
  end

  ssrp_pkg::ssrp_mstate_type st;
  ssrp_pkg::ssrp_mstate_type next_st;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [1:0] byten;
  logic [1:0] next_byten;
  logic [7:0] sh;
  logic [7:0] next_sh;
  logic       scl_o;
  logic       next_scl_o;
  logic       sda_o;
  logic       next_sda_o;
  logic       next_busy;
  logic       next_nack;
  logic [7:0] next_rbyte;
  logic       go;
  assign go = wr && addr == 3'h0 && wdata[0] && !busy;

  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      case (addr)
        3'h0: next_rdata = ctrl;
        3'h1: next_rdata = {7'h00, asel};
        3'h2: next_rdata = ptr;
        3'h3: next_rdata = dat;
        3'h4: next_rdata = {6'h00, nack, busy};
        3'h5: next_rdata = rbyte;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  function automatic logic [7:0] byte_for(input logic [1:0] n);
    if (n == 2'h0)
      byte_for = {`SSRP_ADDR_UPPER, asel, ctrl[1]};
    else if (n == 2'h1)
      byte_for = ptr;
    else
      byte_for = dat;
  endfunction : byte_for

  logic [1:0] last_byte;
  assign last_byte = ctrl[1] ? 2'h1 : (ctrl[2] ? 2'h2 : 2'h1);

  always_comb begin
    next_st    = st;
    next_cnt   = cnt;
    next_bitn  = bitn;
    next_byten = byten;
    next_sh    = sh;
    next_scl_o = scl_o;
    next_sda_o = sda_o;
    next_busy  = busy;
    next_nack  = nack;
    next_rbyte = rbyte;
    if (cnt != 8'h00)
      next_cnt = cnt - 8'h01;
    else begin
      next_cnt = `SSRP_HALF_PERIOD;
      case (st)
        ssrp_pkg::ssrpm_idle_type: begin
          next_cnt = 8'h00;
          // Busy falls only after the bus-free gap that follows a stop,
          // so a go written right after the poll is never dropped.
          next_busy = 1'b0;
          if (go) begin
            next_busy  = 1'b1;
            next_nack  = 1'b0;
            next_st    = ssrp_pkg::ssrpm_start_type;
          end
        end
        ssrp_pkg::ssrpm_start_type: begin
          next_sda_o = 1'b0; // start while clock high
          next_byten = 2'h0;
          next_bitn  = 4'h0;
          next_sh    = byte_for(2'h0);
          next_st    = ssrp_pkg::ssrpm_low_type;
        end
        ssrp_pkg::ssrpm_low_type: begin
          next_scl_o = 1'b0;
          next_st    = ssrp_pkg::ssrpm_high_type;
          // Data changes only while the clock is low.
          if (bitn < 4'h8)
            next_sda_o = (byten == 2'h0 || !ctrl[1]) ? sh[7] : 1'b1;
          else
            next_sda_o = 1'b1; // slave acks a write; a read is not acked
        end
        ssrp_pkg::ssrpm_high_type: begin
          next_scl_o = 1'b1;
          next_st    = ssrp_pkg::ssrpm_low_type;
          if (bitn < 4'h8) begin
            next_sh    = {sh[6:0], 1'b0};
            next_rbyte = (ctrl[1] && byten != 2'h0) ?
                         {rbyte[6:0], sy2[0]} : rbyte;
            next_bitn  = bitn + 4'h1;
          end else begin
            if (!(ctrl[1] && byten != 2'h0) && sy2[0])
              next_nack = 1'b1;
            next_bitn = 4'h0;
            if (byten == last_byte || next_nack)
              next_st = ssrp_pkg::ssrpm_stop0_type;
            else begin
              next_byten = byten + 2'h1;
              next_sh    = byte_for(byten + 2'h1);
            end
          end
        end
        ssrp_pkg::ssrpm_stop0_type: begin
          next_scl_o = 1'b0;
          next_st    = ssrp_pkg::ssrpm_stop1_type;
        end
        ssrp_pkg::ssrpm_stop1_type: begin
          next_sda_o = 1'b0;
          next_st    = ssrp_pkg::ssrpm_stop2_type;
        end
        ssrp_pkg::ssrpm_stop2_type: begin
          if (!sy2[1])
            next_scl_o = 1'b1;
          else begin
            next_sda_o = 1'b1;
            next_st    = ssrp_pkg::ssrpm_idle_type;
          end
        end
        default: next_st = ssrp_pkg::ssrpm_idle_type;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st    <= ssrp_pkg::ssrpm_idle_type;
      cnt   <= 8'h00;
      bitn  <= 4'h0;
      byten <= 2'h0;
      sh    <= 8'h00;
      scl_o <= 1'b1;
      sda_o <= 1'b1;
      busy  <= 1'b0;
      nack  <= 1'b0;
      rbyte <= 8'h00;
      ctrl  <= 8'h00;
      ptr   <= 8'h00;
      dat   <= 8'h00;
      asel  <= 1'b0;
      rdata <= 8'h00;
    end else begin
      st    <= next_st;
      cnt   <= next_cnt;
      bitn  <= next_bitn;
      byten <= next_byten;
      sh    <= next_sh;
      scl_o <= next_scl_o;
      sda_o <= next_sda_o;
      busy  <= next_busy;
      nack  <= next_nack;
      rbyte <= next_rbyte;
      rdata <= next_rdata;
      if (wr && addr == 3'h0 && !busy) ctrl <= {wdata[7:1], 1'b0};
      if (wr && addr == 3'h1) asel <= wdata[0];
      if (wr && addr == 3'h2) ptr <= wdata;
      if (wr && addr == 3'h3) dat <= wdata;
    end
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = !scl_o;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = !sda_o;
endmodule : ssrp_master
`default_nettype wire

/* tb/ssrp_properties.sv */
`default_nettype none
module ssrp_properties (
  input wire logic sys_clk,   // system clock
  input wire logic reset,     // synchronous reset
  input wire logic scl,       // resolved clock line
  input wire logic sda,       // resolved data line
  input wire logic sda_m_o,   // master data level
  input wire logic sda_m_oe,  // master data enable
  input wire logic sda_s_o,   // device data level
  input wire logic sda_s_oe   // device data enable
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       rw;
  logic       acked;
  logic [5:0] pulses;
  wire dev_low = sda_s_oe && !sda_s_o;
  wire mst_low = sda_m_oe && !sda_m_o;
  wire rise    = scl && !scl_q;
  wire start   = scl && scl_q && sda_q && !sda;
  wire stop    = scl && scl_q && !sda_q && sda;
  // Pulses count rising clock edges since the last start; it saturates
  // so a stuck bus cannot wrap it back into a legal count.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      pulses <= 6'h00;
      rw     <= 1'b0;
      acked  <= 1'b0;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (start) pulses <= 6'h00;
      else if (rise && pulses != 6'h3f) pulses <= pulses + 6'h01;
      if (rise && pulses == 6'h07) rw <= sda;
      if (rise && pulses == 6'h08) acked <= !sda;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  AST_DEV_STABLE_HIGH: assert property (
    (scl && $past(scl)) |-> $stable(dev_low))
    else $error("device data drive moved while clock high");
  AST_ADDR_NO_DRIVE: assert property (
    (pulses < 6'h08) |-> !dev_low)
    else $error("device drove data during address bits");
  AST_MASTER_RELEASE_ACK: assert property (
    (pulses == 6'h09 && scl && scl_q) |-> !mst_low)
    else $error("master held data during address acknowledge");
  AST_STOP_COUNT: assert property (
    stop |-> (pulses == 6'h0a || pulses == 6'h13 || pulses == 6'h1c))
    else $error("stop after an illegal pulse count");
  AST_READ_NACK: assert property (
    (rw && pulses == 6'h12 && scl && scl_q) |-> sda)
    else $error("read byte was acknowledged");
  AST_WRITE_ACK: assert property (
    (!rw && acked && (pulses == 6'h12 || pulses == 6'h1b) && scl && scl_q)
    |-> !sda)
    else $error("write byte not acknowledged");
  AST_SCL_HIGH: assert property (
    $rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  AST_SCL_LOW: assert property (
    $fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  COV_WRITE2: cover property (stop && pulses == 6'h1c);
  COV_READ: cover property (stop && pulses == 6'h13 && rw);
  COV_NACK: cover property (stop && pulses == 6'h0a);
endmodule : ssrp_properties
`default_nettype wire

/* tb/supervisor_serial_register_port_bench.sv */
`default_nettype none
`include "ssrp_consts.svh"
`define CHECK(got, exp) \
  begin \
    if ((got) !== (exp)) begin \
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
      fail_count++; \
    end \
    cmp_count++; \
  end
module supervisor_serial_register_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk;
  logic       reset;
  logic [1:0] first;
  logic [1:0] second;
  logic       cutoff;
  logic       sel;
  logic       prog_ok;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic [7:0] pointer;
  logic [7:0] wbyte;
  logic [7:0] dis;
  logic [7:0] status;
  logic [7:0] stat;
  logic [7:0] rbyte;
  logic       dev_o;
  logic       dev_oe;
  logic       strobe;
  int         strobes = 0;
  int         fail_count;
  int         cmp_count;
  logic [3:0] in_tab [6] = '{4'h4, 4'h8, 4'h1, 4'h5, 4'h9, 4'h0};
  logic [2:0] code_tab [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h0};
  logic [7:0] dat_tab [4] = '{8'h09, 8'h02, 8'h00, 8'hff};
  logic [7:0] dis_tab [4] = '{8'h09, 8'h0b, 8'h0b, 8'h1b};
  // ----------------------------------------------------------------
  // Both ends joined over one link
  // ----------------------------------------------------------------
  ssrp_if link ();
  ssrp_device ssrp_device_inst (
    .sys_clk(sys_clk), .reset(reset), .bus(link),
    .first_high_voltage_input(first), .second_high_voltage_input(second),
    .supply_cutoff_output(cutoff), .slave_address_select_pin(sel),
    .prog_verify_ok(prog_ok), .sda_o(dev_o), .sda_oe(dev_oe),
    .register_pointer(pointer), .write_data(wbyte), .write_strobe(strobe),
    .disable_bits(dis), .fault_status(status));
  ssrp_master ssrp_master_inst (
    .sys_clk(sys_clk), .reset(reset), .bus(link), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ssrp_properties ssrp_properties_inst (
    .sys_clk(sys_clk), .reset(reset), .scl(link.scl), .sda(link.sda),
    .sda_m_o(link.sda_m_o), .sda_m_oe(link.sda_m_oe),
    .sda_s_o(link.sda_s_o), .sda_s_oe(link.sda_s_oe));
  always @(posedge sys_clk) if (strobe === 1'b1) strobes <= strobes + 1;
  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(posedge sys_clk);
    d = rdata;
  endtask : reg_rd
  // The poll is bounded by the watchdog, not here, so a hung link ends
  // the run through the single closing path.
  task automatic xfer(input logic [7:0] ctrl);
    reg_wr(3'h0, ctrl);
    stat = 8'h01;
    while (stat[0] !== 1'b0) reg_rd(3'h4, stat);
  endtask : xfer
  task automatic conclude;
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end
  initial begin
    reset = 1'b1; first = 2'h0; second = 2'h0; cutoff = 1'b0;
    sel = 1'b1; prog_ok = 1'b0; addr = 3'h0; wdata = 8'h00;
    wr = 1'b0; rd = 1'b0; fail_count = 0; cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHECK(status, `SSRP_STATUS_RESET)
    for (int i = 0; i < 16; i++) begin
      {first, second} <= i[3:0];
      repeat (4) @(posedge sys_clk);
      `CHECK(status[3:0], i[3:0])
      `CHECK(status[6:4], `SSRP_CODE_OFF)
    end
    for (int i = 0; i < 6; i++) begin
      {first, second} <= in_tab[i];
      repeat (4) @(posedge sys_clk);
      cutoff <= 1'b1;
      // Two synchroniser stages, the capture and the output register.
      repeat (5) @(posedge sys_clk);
      `CHECK(status[6:4], code_tab[i])
      cutoff <= 1'b0;
    end
    // Set-only bits: a later zero must not clear what was set.
    reg_wr(3'h1, 8'h01);
    reg_wr(3'h2, {1'b0, `SSRP_REG_DISABLE});
    for (int i = 0; i < 4; i++) begin
      reg_wr(3'h3, dat_tab[i]);
      xfer(8'h05);
      `CHECK(stat[1], 1'b0)
      `CHECK(pointer, {1'b0, `SSRP_REG_DISABLE})
      `CHECK(wbyte, dat_tab[i])
      `CHECK(dis, dis_tab[i])
    end
    `CHECK(strobes, 4)
    reg_wr(3'h2, {1'b0, `SSRP_REG_STATUS});
    reg_wr(3'h3, 8'hff);
    xfer(8'h05);
    `CHECK(status, 8'h00)
    `CHECK(strobes, 5)
    first <= 2'h1;
    second <= 2'h2;
    xfer(8'h01);
    `CHECK(pointer, {1'b0, `SSRP_REG_STATUS})
    for (int i = 0; i < 2; i++) begin
      xfer(8'h03);
      reg_rd(3'h5, rbyte);
      `CHECK(rbyte, 8'h06)
      `CHECK(status, 8'h06)
    end
    prog_ok <= 1'b1;
    reg_wr(3'h2, {1'b1, `SSRP_REG_STATUS});
    xfer(8'h01);
    xfer(8'h03);
    reg_rd(3'h5, rbyte);
    `CHECK(rbyte, 8'h86)
    reg_wr(3'h2, {1'b0, `SSRP_REG_STATUS});
    xfer(8'h01);
    xfer(8'h03);
    reg_rd(3'h5, rbyte);
    `CHECK(rbyte, 8'h06)
    // A foreign address must leave the pointer alone.
    reg_wr(3'h1, 8'h00);
    reg_wr(3'h2, {1'b0, `SSRP_REG_DISABLE});
    xfer(8'h01);
    `CHECK(stat[1], 1'b1)
    `CHECK(pointer, {1'b0, `SSRP_REG_STATUS})
    sel <= 1'b0;
    xfer(8'h01);
    `CHECK(stat[1], 1'b0)
    `CHECK(pointer, {1'b0, `SSRP_REG_DISABLE})
    `CHECK(strobes, 5)
    `CHECK({dev_o, dev_oe}, 2'h0)
    conclude();
  end
endmodule : supervisor_serial_register_port_bench
`undef CHECK
`default_nettype wire
